/* core/pabmux_pkg.sv */
// Package: constants and carrier types for the port A/B pin function mux
package pabmux_pkg;

    // ==========================================================
    // Interface-mode field
    // ==========================================================
    localparam int IFM_W = 2;
    // Field value to function table; all-port is the safe default
    localparam logic [3:0] IFM_FIFO_MAP_RST = 4'h8;    // value 3 selects slave FIFO
    localparam logic [3:0] IFM_DBUS_MAP_RST = 4'hC;    // values 2,3 use data bus

    // ==========================================================
    // Field positions
    // ==========================================================
    localparam int POL_SLAVE_FIFO_OUTPUT_ENABLE_BIT = 4;
    localparam int POL_PKTC_BIT = 5;
    localparam int WAKE_ALT_BIT = 7;
    localparam int WAKE_EN_BIT = 1;
    localparam int WAKE_POL_BIT = 4;
    localparam int OEA_BIT3 = 3;
    localparam int PACFG_BIT7 = 7;

    // ==========================================================
    // Pin indices inside the nine-pin group
    // ==========================================================
    localparam int NPINS = 9;
    localparam int PIN_A2 = 0;
    localparam int PIN_A3 = 1;
    localparam int PIN_A4 = 2;
    localparam int PIN_A5 = 3;
    localparam int PIN_A6 = 4;
    localparam int PIN_A7 = 5;
    localparam int PIN_B0 = 6;

    localparam logic [2:0] SYNC_RST = 3'h0;

    // ==========================================================
    // Carriers
    // ==========================================================
    typedef struct packed {
        logic [8:0] in;
        logic [8:0] out;
        logic [8:0] oe;
    } pabmux_pins_t;

    typedef struct packed {
        logic outputEnable;
        logic fifoSelect1;
        logic fifoSelect0;
        logic packetCommit;
        logic chipSelectActive;
    } pabmux_fifo_t;

endpackage : pabmux_pkg

/* core/pabmux_port_ab_mux.sv */
// Port A bits 2..7 and port B bits 0..2 pin function multiplexer
// Function
// - Mode field picks port_a_bit2 function
// - Output-enable pin input only, polarity bit
// - Wake bit 7 and enable bit3 pick
// - Wake source enabled by bit 1, polarity bit4
// - Suspended wake transition restarts oscillator, interrupts
// - Asserted enabled wake pin blocks suspend
// - FIFO select pins are input only
// - Packet commit input, polarity bit 5
// - Mode and config bit pick bit7 function
// - Fourth flag drives pin as output
// - Chip select gates all FIFO strobes but the FIFO select inputs
// - Port B bits 0-2 carry data bus
// - Port mode bidirectional, input by default
// - Reset holds all pins high impedance
`timescale 1ns/1ps
module pabmux_port_ab_mux
    import pabmux_pkg::*;
#(
    parameter logic [3:0] FIFO_MAP = IFM_FIFO_MAP_RST,
    parameter logic [3:0] DBUS_MAP = IFM_DBUS_MAP_RST,
    parameter int DBUS_W = 3
)(
    input wire logic clock,
    input wire logic nrst,
    input wire logic [IFM_W-1:0] interfaceModeSetting,
    input wire logic [7:0] fifoPinPolaritySetting,
    input wire logic [7:0] wakeControlSetting,
    input wire logic [7:0] portAOutputEnables,
    input wire logic [7:0] portAAltFunctionSetting,
    input wire logic [8:0] portOut,
    input wire logic [8:0] portOe,
    input wire logic fourthFifoFlag,
    input wire logic [DBUS_W-1:0] fifoDataOut,
    input wire logic fifoDataOe,
    input wire logic suspended,
    input wire pabmux_pins_t pinIn,
    output pabmux_pins_t pins,
    output logic [8:0] portIn,
    output logic [DBUS_W-1:0] fifoDataIn,
    output pabmux_fifo_t fifoCtl,
    output logic wakeRestartOsc,
    output logic wakeIrq,
    output logic suspendBlock
);

    // Pad slice is fixed by the three port B pins
    if (DBUS_W != 3)
    begin : g_dbusWidthCheck
        $error("pabmux: data bus slice must be 3 bits");
    end

    // ==========================================================
    // Reset release
    // ==========================================================
    logic [1:0] rstSync_r;
    logic rstN;
    always_ff @(posedge clock or negedge nrst)
    begin
        if (!nrst)
            rstSync_r <= 2'h0;
        else
            rstSync_r <= {rstSync_r[0], 1'b1};
    end
    assign rstN = rstSync_r[1];

    // ==========================================================
    // Pin input synchronisers, second and third must agree
    // ==========================================================
    logic [8:0] s1_r, s2_r, s3_r, pinSync_r;
    always_ff @(posedge clock or negedge rstN)
    begin
        if (!rstN)
        begin
            s1_r <= 9'h000;
            s2_r <= 9'h000;
            s3_r <= 9'h000;
            pinSync_r <= 9'h000;
        end
        else
        begin
            s1_r <= pinIn.in;
            s2_r <= s1_r;
            s3_r <= s2_r;
            for (int i = 0; i < NPINS; i++)
                if (s2_r[i] == s3_r[i])
                    pinSync_r[i] <= s3_r[i];
        end
    end

    // ==========================================================
    // Function select
    // ==========================================================
    function automatic logic modeHit(input logic [3:0] map, input logic [IFM_W-1:0] m);
        modeHit = map[m];
    endfunction : modeHit

    logic fifoMode, dbusMode, wakeAlt, flagMode, csMode;
    assign fifoMode = modeHit(FIFO_MAP, interfaceModeSetting);
    assign dbusMode = modeHit(DBUS_MAP, interfaceModeSetting);
    // Wake function only while the port bit is not driven
    assign wakeAlt = wakeControlSetting[WAKE_ALT_BIT] &
                     !portAOutputEnables[OEA_BIT3];
    assign flagMode = fifoMode & !portAAltFunctionSetting[PACFG_BIT7];
    assign csMode = fifoMode & portAAltFunctionSetting[PACFG_BIT7];

    // ==========================================================
    // Pin drivers
    // ==========================================================
    logic [8:0] altIn, outNxt, oeNxt;
    always_comb
    begin
        outNxt = portOut;
        oeNxt = portOe;
        altIn = 9'h000;
        if (fifoMode)
        begin
            altIn[PIN_A2] = 1'b1;
            altIn[PIN_A4] = 1'b1;
            altIn[PIN_A5] = 1'b1;
            altIn[PIN_A6] = 1'b1;
            altIn[PIN_A7] = 1'b1;
        end
        if (wakeAlt)
            altIn[PIN_A3] = 1'b1;
        if (dbusMode)
            altIn[PIN_B0 +: 3] = 3'h7;
        for (int i = 0; i < NPINS; i++)
            if (altIn[i])
                oeNxt[i] = 1'b0;
        if (flagMode)
        begin
            outNxt[PIN_A7] = fourthFifoFlag;
            oeNxt[PIN_A7] = 1'b1;
        end
        if (dbusMode)
        begin
            outNxt[PIN_B0 +: 3] = fifoDataOut;
            oeNxt[PIN_B0 +: 3] = {3{fifoDataOe}};
        end
    end

    // Registered drivers; reset leaves every pin undriven
    logic [8:0] padOut_r, padOe_r;
    always_ff @(posedge clock or negedge rstN)
    begin
        if (!rstN)
        begin
            padOut_r <= 9'h000;
            padOe_r <= 9'h000;
        end
        else
        begin
            padOut_r <= outNxt;
            padOe_r <= oeNxt;
        end
    end
    // One driver for the whole pad carrier
    assign pins = '{in: pinSync_r, out: padOut_r, oe: padOe_r};

    always_ff @(posedge clock or negedge rstN)
    begin
        if (!rstN)
        begin
            portIn <= 9'h000;
            fifoDataIn <= 3'h0;
        end
        else
        begin
            portIn <= pinSync_r;
            fifoDataIn <= pinSync_r[PIN_B0 +: 3];
        end
    end

    // ==========================================================
    // Slave FIFO controls
    // ==========================================================
    logic csOk;
    // Chip select is active low; without it every strobe but the FIFO selects reads inactive
    assign csOk = !csMode | !pinSync_r[PIN_A7];
    always_ff @(posedge clock or negedge rstN)
    begin
        if (!rstN)
            fifoCtl <= '0;
        else
        begin
            fifoCtl.chipSelectActive <= fifoMode & csOk;
            fifoCtl.outputEnable <= fifoMode & csOk &
                (pinSync_r[PIN_A2] == fifoPinPolaritySetting[POL_SLAVE_FIFO_OUTPUT_ENABLE_BIT]);
            fifoCtl.packetCommit <= fifoMode & csOk &
                (pinSync_r[PIN_A6] == fifoPinPolaritySetting[POL_PKTC_BIT]);
            fifoCtl.fifoSelect0 <= fifoMode & pinSync_r[PIN_A4];
            fifoCtl.fifoSelect1 <= fifoMode & pinSync_r[PIN_A5];
        end
    end

    // ==========================================================
    // Second wake input
    // ==========================================================
    logic wakeEn, wakeLvl, wakePrev_r;
    assign wakeEn = wakeAlt & wakeControlSetting[WAKE_EN_BIT];
    assign wakeLvl = pinSync_r[PIN_A3] == wakeControlSetting[WAKE_POL_BIT];
    always_ff @(posedge clock or negedge rstN)
    begin
        if (!rstN)
        begin
            wakePrev_r <= 1'b0;
            wakeRestartOsc <= 1'b0;
            wakeIrq <= 1'b0;
            suspendBlock <= 1'b0;
        end
        else
        begin
            wakePrev_r <= pinSync_r[PIN_A3];
            // Any transition wakes, whatever the polarity setting
            wakeRestartOsc <= suspended & wakeEn & (wakePrev_r != pinSync_r[PIN_A3]);
            wakeIrq <= suspended & wakeEn & (wakePrev_r != pinSync_r[PIN_A3]);
            suspendBlock <= wakeEn & wakeLvl;
        end
    end

endmodule : pabmux_port_ab_mux

/* test/pabmux_far_end.sv */
// Far-end host model on the multiplexed pads
`timescale 1ns/1ps
module pabmux_far_end
    import pabmux_pkg::*;
(
    input wire pabmux_pins_t pins,
    input wire logic [8:0] hostDrive,
    output pabmux_pins_t pinIn
);
    // ====
    // Host strobes are plain levels; it yields every pad the device drives
    assign pinIn = '{
        in: (pins.out & pins.oe) | (hostDrive & ~pins.oe), out: 9'h000, oe: 9'h000};
endmodule : pabmux_far_end

/* test/pabmux_port_ab_mux_assertions.sv */
// Checker: pad drive and wake pulse properties
`timescale 1ns/1ps
module pabmux_port_ab_mux_assertions
    import pabmux_pkg::*;
#(
    parameter logic [3:0] FIFO_MAP = IFM_FIFO_MAP_RST,
    parameter logic [3:0] DBUS_MAP = IFM_DBUS_MAP_RST
)(
    input wire logic clock,
    input wire logic nrst,
    input wire logic [IFM_W-1:0] interfaceModeSetting,
    input wire logic [7:0] wakeControlSetting,
    input wire logic [7:0] portAOutputEnables,
    input wire logic [7:0] portAAltFunctionSetting,
    input wire logic [8:0] portOut,
    input wire logic [8:0] portOe,
    input wire logic fourthFifoFlag,
    input wire pabmux_pins_t pins,
    input wire logic wakeIrq
);
    // ====
    // Judge only once the two-flop reset copy has let go
    logic [1:0] upCnt_r;
    wire live = upCnt_r == 2'h3;
    wire fifo = live && FIFO_MAP[interfaceModeSetting];
    always_ff @(posedge clock or negedge nrst)
    begin
        if (!nrst)
            upCnt_r <= 2'h0;
        else
            upCnt_r <= upCnt_r + {1'b0, !live};
    end
    default clocking @(posedge clock); endclocking
    default disable iff (!nrst);
    a_reset_all_float: assert property (
        disable iff (1'b0) !nrst |-> pins.oe == 9'h000) else $error("pad driven in reset");
    a_port_follow: assert property (
        live && !FIFO_MAP[interfaceModeSetting] |=> pins.oe[0] == $past(portOe[0])
        && (!pins.oe[0] || pins.out[0] == $past(portOut[0]))) else $error("port drive");
    a_fifo_inputs: assert property (
        fifo |=> (pins.oe & 9'h01d) == 9'h000) else $error("fifo input driven");
    a_wake_alt_input: assert property (
        live && wakeControlSetting[7] && !portAOutputEnables[3] |=> !pins.oe[1])
        else $error("wake pad driven");
    a_flag_drive_out: assert property (
        fifo && !portAAltFunctionSetting[7] |=> pins.oe[5]
        && pins.out[5] == $past(fourthFifoFlag)) else $error("flag not driven");
    a_chip_sel_input: assert property (
        fifo && portAAltFunctionSetting[7] |=> !pins.oe[5]) else $error("select driven");
    a_port_b_follow: assert property (
        live && !DBUS_MAP[interfaceModeSetting] |=> pins.oe[8:6] == $past(portOe[8:6]))
        else $error("port b drive");
    a_wake_pulse_one: assert property ($rose(wakeIrq) |=> !wakeIrq)
        else $error("wake pulse too long");
endmodule : pabmux_port_ab_mux_assertions

bind pabmux_port_ab_mux pabmux_port_ab_mux_assertions
    #(.FIFO_MAP(FIFO_MAP), .DBUS_MAP(DBUS_MAP))
    i_pabmux_chk (.clock, .nrst, .interfaceModeSetting, .wakeControlSetting,
    .portAOutputEnables, .portAAltFunctionSetting, .portOut, .portOe, .fourthFifoFlag,
    .pins, .wakeIrq);

/* test/pabmux_port_ab_mux_tb.sv */
// Testbench: random and corner checks of the pin function mux
`timescale 1ns/1ps
module pabmux_port_ab_mux_tb
    import pabmux_pkg::*;
    ;
    logic clock = 1'b0;
    logic nrst, flag, dOe, susp, wakeIrq, wakeOsc, suspBlk, ok;
    logic [1:0] mode;
    logic [2:0] dOut, fdIn;
    logic [4:0] fc;
    logic [7:0] pol, wake, port_a_output_enables, cfg, nI, nO;
    logic [8:0] pOut, pOe, host, pad, portIn;
    logic [17:0] e;
    int numErrors = 0;
    int comparisons = 0;
    pabmux_pins_t pins, pinIn;
    pabmux_fifo_t fifoCtl;
    always #2 clock = ~clock;
    pabmux_port_ab_mux i_pabmux_port_ab_mux (.clock, .nrst, .interfaceModeSetting(mode),
        .fifoPinPolaritySetting(pol), .wakeControlSetting(wake), .portAOutputEnables(port_a_output_enables),
        .portAAltFunctionSetting(cfg), .portOut(pOut), .portOe(pOe), .fourthFifoFlag(flag),
        .fifoDataOut(dOut), .fifoDataOe(dOe), .suspended(susp), .pinIn, .pins, .portIn,
        .fifoDataIn(fdIn), .fifoCtl, .wakeRestartOsc(wakeOsc), .wakeIrq, .suspendBlock(suspBlk));
    pabmux_far_end i_pabmux_far_end (.pins, .hostDrive(host), .pinIn);
    task automatic check(input logic [17:0] got, input logic [17:0] exp);
        comparisons++;
        if (got !== exp)
        begin
            numErrors++;
            $display("BAD %0t got %h exp %h", $time, got, exp);
        end
    endtask : check
    task automatic completeRun();
        $display("errors %0d comparisons %0d", numErrors, comparisons);
        if (numErrors == 0 && comparisons > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask : completeRun
    // ====
    // Pad drive expected one edge after the settings
    function automatic logic [17:0] expDrive();
        logic [8:0] o;
        logic [8:0] d;
        o = pOut;
        d = pOe & {7'h7f, !(wake[7] && !port_a_output_enables[3]), 1'b1};
        if (IFM_FIFO_MAP_RST[mode])
            {d, o[5]} = {d[8:6], !cfg[7], 3'h0, d[1], 1'b0, flag};
        if (IFM_DBUS_MAP_RST[mode])
            {d[8:6], o[8:6]} = {{3{dOe}}, dOut};
        return {o & d, d};
    endfunction : expDrive
    initial
    begin
        // Reset falls after time zero so every flop sees the edge
        nrst = 1'b1;
        {mode, pol, wake, port_a_output_enables, cfg, pOut, pOe, host, flag, dOut, dOe, susp} = '0;
        #1 nrst = 1'b0;
        void'($urandom(32'h0000_bf58));
        repeat (3) @(posedge clock);
        #1 nrst = 1'b1;
        repeat (2) @(posedge clock);
        repeat (300)
        begin
            @(posedge clock);
            #1 {mode, pol, wake, port_a_output_enables, cfg} = 34'({$urandom, $urandom});
            {pOut, pOe, host, flag, dOut, dOe, susp} = 33'({$urandom, $urandom});
            e = expDrive();
            pad = e[17:9] | (host & ~e[8:0]);
            ok = !(cfg[7] && pad[5]);
            fc = {5{IFM_FIFO_MAP_RST[mode]}} &
                {ok & (pad[0] ~^ pol[4]), pad[3:2], ok & (pad[4] ~^ pol[5]), ok};
            @(posedge clock);
            #1 check({pins.out & e[8:0], pins.oe}, e);
            // Pads pass a four-flop filter, so allow the full settle
            repeat (7) @(posedge clock);
            #1 check({fdIn, 6'h00, portIn}, {pad[8:6], 6'h00, pad});
            check({9'h000, pins.in}, {9'h000, pad});
            check({13'h0000, fifoCtl}, {13'h0000, fc});
        end
        // Upper half of the sweep runs awake, so no wake pulse may appear
        for (int k = 0; k < 8; k++)
        begin
            @(posedge clock);
            #1 {mode, port_a_output_enables, pOe, susp, host[1]} = {19'h0_0000, !k[2], !k[1]};
            wake = {1'b1, 2'h0, k[1], 2'h0, k[0], 1'b0};
            repeat (8) @(posedge clock);
            #1 {host[1], nI, nO} = {k[1], 16'h0000};
            repeat (10)
            begin
                @(posedge clock);
                #1 {nI, nO} = {nI + 8'(wakeIrq), nO + 8'(wakeOsc)};
            end
            check({1'b0, suspBlk, nI, nO},
                {1'b0, k[0], 7'h00, k[0] & !k[2], 7'h00, k[0] & !k[2]});
        end
        pOe = 9'h1ff;
        repeat (2) @(posedge clock);
        #1 nrst = 1'b0;
        #1 check({9'h000, pins.oe}, 18'h0_0000);
        completeRun();
    end
    initial
    begin
        #40000;
        numErrors++;
        completeRun();
    end
endmodule : pabmux_port_ab_mux_tb
